// ### verilog/cwio_console_unit.sv
/*
 Console word input/output unit: executes type-in and print instructions.
 Assumes a sequencer that issues one instruction pulse and waits for done,
 a memory with one-cycle read latency, and a console keyboard/printer.
*/
// Notes on behaviour
// - Type-in halts program and lights indicator
// - Type-in stores one keyboard word at address
// - Stay halted until release, then resume
// - Print sends word at address to printer
// - Print resumes once word is held
// - Any memory address accepted for both
`timescale 1ns/1ps
module cwio_console_unit
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire logic [1:0] instr_op_i,
    input wire logic [cwio_pkg::ADDR_W-1:0] instr_addr_i,
    input wire logic key_valid_i,
    input wire logic [cwio_pkg::WORD_W-1:0] key_word_i,
    input wire logic release_i,
    input wire logic [cwio_pkg::WORD_W-1:0] mem_rdata_i,
    input wire logic prn_ready_i,
    output logic done_o,
    output logic halt_o,
    output logic indicator_o,
    output logic key_ready_o,
    output logic mem_we_o,
    output logic mem_re_o,
    output logic [cwio_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [cwio_pkg::WORD_W-1:0] mem_wdata_o,
    output logic prn_valid_o,
    output logic [cwio_pkg::WORD_W-1:0] prn_word_o
);
    cwio_pkg::cwio_state_t state_r; // Operation state
    cwio_pkg::cwio_state_t state_nxt;
    logic done_r; // Completion pulse to sequencer
    logic done_nxt;
    logic halt_r; // Program halted
    logic halt_nxt;
    logic ind_r; // Operator indicator
    logic ind_nxt;
    logic kready_r; // Keyboard may send
    logic kready_nxt;
    logic we_r; // Memory write strobe
    logic we_nxt;
    logic re_r; // Memory read strobe
    logic re_nxt;
    logic [cwio_pkg::ADDR_W-1:0] addr_r; // Target address
    logic [cwio_pkg::ADDR_W-1:0] addr_nxt;
    logic [cwio_pkg::WORD_W-1:0] wdata_r; // Keyboard word
    logic [cwio_pkg::WORD_W-1:0] wdata_nxt;
    logic hold_load; // Copy memory word into holding store
    logic hold_full; // Holding store occupied
    logic prn_take; // Printer accepts word
    logic type_in_hit; // Type-in instruction offered
    logic print_hit; // Print instruction offered

    ////////////////////////////////////////////////////////////////////
    // Decode of one offered instruction code
    function automatic logic cwio_op_hit
    (
        input logic valid,
        input logic [1:0] op,
        input logic [1:0] code
    );
        begin
            cwio_op_hit = valid && (op == code);
        end
    endfunction : cwio_op_hit

    // Instruction decode, looked at only while idle
    assign type_in_hit = cwio_op_hit(instr_valid_i, instr_op_i, cwio_pkg::OP_TYPE_IN);
    assign print_hit = cwio_op_hit(instr_valid_i, instr_op_i, cwio_pkg::OP_PRINT);

    ////////////////////////////////////////////////////////////////////
    // Holding store toward the printer
    assign prn_take = hold_full & prn_ready_i;

    cwio_hold_store u_hold
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .load_i(hold_load),
        .word_i(mem_rdata_i),
        .taken_i(prn_take),
        .full_o(hold_full),
        .word_o(prn_word_o)
    );

    assign prn_valid_o = hold_full;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic of the instruction sequence
    always_comb
    begin
        state_nxt = state_r;
        done_nxt = 1'b0;
        halt_nxt = halt_r;
        ind_nxt = ind_r;
        kready_nxt = kready_r;
        we_nxt = 1'b0;
        re_nxt = 1'b0;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        hold_load = 1'b0;
        case (state_r)
            cwio_pkg::CWIO_IDLE:
            begin
                // Any address is taken as given
                addr_nxt = instr_addr_i;
                if (type_in_hit)
                begin
                    halt_nxt = 1'b1;
                    ind_nxt = 1'b1;
                    kready_nxt = 1'b1;
                    state_nxt = cwio_pkg::CWIO_WAIT_KEY;
                end
                else if (print_hit)
                begin
                    re_nxt = 1'b1;
                    state_nxt = cwio_pkg::CWIO_READ;
                end
            end
            cwio_pkg::CWIO_WAIT_KEY:
            begin
                // Exactly one word is taken, then keyboard is closed
                if (key_valid_i)
                begin
                    kready_nxt = 1'b0;
                    wdata_nxt = key_word_i;
                    we_nxt = 1'b1;
                    state_nxt = cwio_pkg::CWIO_WRITE;
                end
            end
            cwio_pkg::CWIO_WRITE:
            begin
                state_nxt = cwio_pkg::CWIO_WAIT_REL;
            end
            cwio_pkg::CWIO_WAIT_REL:
            begin
                // Program position held by sequencer until done
                if (release_i)
                begin
                    halt_nxt = 1'b0;
                    ind_nxt = 1'b0;
                    done_nxt = 1'b1;
                    state_nxt = cwio_pkg::CWIO_IDLE;
                end
            end
            cwio_pkg::CWIO_READ:
            begin
                // Read data arrives next cycle
                state_nxt = cwio_pkg::CWIO_LOAD;
            end
            cwio_pkg::CWIO_LOAD:
            begin
                // Wait only for the holding store, not printing
                if (!hold_full || prn_ready_i)
                begin
                    hold_load = 1'b1;
                    done_nxt = 1'b1;
                    state_nxt = cwio_pkg::CWIO_IDLE;
                end
                else
                begin
                    re_nxt = 1'b1;
                    state_nxt = cwio_pkg::CWIO_READ;
                end
            end
            default:
            begin
                state_nxt = cwio_pkg::CWIO_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_r <= cwio_pkg::CWIO_IDLE;
            done_r <= 1'b0;
            halt_r <= 1'b0;
            ind_r <= 1'b0;
            kready_r <= 1'b0;
            we_r <= 1'b0;
            re_r <= 1'b0;
            addr_r <= cwio_pkg::ADDR_RST;
            wdata_r <= cwio_pkg::WORD_RST;
        end
        else
        begin
            state_r <= state_nxt;
            done_r <= done_nxt;
            halt_r <= halt_nxt;
            ind_r <= ind_nxt;
            kready_r <= kready_nxt;
            we_r <= we_nxt;
            re_r <= re_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign done_o = done_r;
    assign halt_o = halt_r;
    assign indicator_o = ind_r;
    assign key_ready_o = kready_r;
    assign mem_we_o = we_r;
    assign mem_re_o = re_r;
    assign mem_addr_o = addr_r;
    assign mem_wdata_o = wdata_r;
endmodule : cwio_console_unit

// ### verilog/cwio_pkg.sv
/*
 Package for the console word input/output instruction unit.
 Holds word and address widths, opcode codes, reset values and operation states.
 Assumes a single 100 MHz clock and an asynchronous active-high reset.
*/
package cwio_pkg;
    // Width of one memory word and of one address
    localparam int WORD_W = 48;
    localparam int ADDR_W = 10;
    // Instruction codes as seen on the command port
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_TYPE_IN = 2'h1;
    localparam logic [1:0] OP_PRINT = 2'h2;
    // Reset values
    localparam logic [47:0] WORD_RST = 48'h0000_0000_0000;
    localparam logic [9:0] ADDR_RST = 10'h000;
    // Operation states
    typedef enum logic [2:0] {
        CWIO_IDLE,
        CWIO_WAIT_KEY,
        CWIO_WRITE,
        CWIO_WAIT_REL,
        CWIO_READ,
        CWIO_LOAD
    } cwio_state_t;
endpackage : cwio_pkg

// ### verilog/cwio_hold_store.sv
/*
 Intermediate output holding store: one word register for the printer.
 Assumes the printer takes the word with a valid/ready handshake.
*/
`timescale 1ns/1ps
module cwio_hold_store
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire logic [cwio_pkg::WORD_W-1:0] word_i,
    input wire logic taken_i,
    output logic full_o,
    output logic [cwio_pkg::WORD_W-1:0] word_o
);
    logic full_r; // Word waiting for printer
    logic full_nxt;
    logic [cwio_pkg::WORD_W-1:0] word_r; // Held word
    logic [cwio_pkg::WORD_W-1:0] word_nxt;

    ////////////////////////////////////////////////////////////////////
    // Next value: load wins over a take in the same cycle
    always_comb
    begin
        full_nxt = full_r;
        word_nxt = word_r;
        if (taken_i)
        begin
            full_nxt = 1'b0;
        end
        if (load_i)
        begin
            full_nxt = 1'b1;
            word_nxt = word_i;
        end
    end

    // Registers
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            full_r <= 1'b0;
            word_r <= cwio_pkg::WORD_RST;
        end
        else
        begin
            full_r <= full_nxt;
            word_r <= word_nxt;
        end
    end

    assign full_o = full_r;
    assign word_o = word_r;
endmodule : cwio_hold_store

// ### verification/cwio_console_props.sv
/* Port checker for the console unit.
 Assumes one clock; bound to every unit instance. */
`timescale 1ns/1ps
module cwio_console_props
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire logic [1:0] instr_op_i,
    input wire logic [9:0] instr_addr_i,
    input wire logic key_valid_i,
    input wire logic [47:0] key_word_i,
    input wire logic release_i,
    input wire logic [47:0] mem_rdata_i,
    input wire logic done_o,
    input wire logic halt_o,
    input wire logic indicator_o,
    input wire logic key_ready_o,
    input wire logic mem_we_o,
    input wire logic mem_re_o,
    input wire logic [9:0] mem_addr_o,
    input wire logic [47:0] mem_wdata_o,
    input wire logic prn_valid_o,
    input wire logic [47:0] prn_word_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic busy_r; // Instruction in flight
    logic [9:0] addr_r; // Target of that instruction
    logic take;
    assign take = instr_valid_i && (!busy_r || done_o) && instr_op_i != 2'h0;
    // Track acceptance; a new instruction may be taken in the done cycle itself
    always_ff @(posedge clk_i or posedge reset_i)
        if (reset_i)
            busy_r <= 1'b0;
        else
            busy_r <= take || (busy_r && !done_o);
    always_ff @(posedge clk_i)
        if (take)
            addr_r <= instr_addr_i;
    ////////////////////////////////////////////////////////////////
    property p_type_halt; take && instr_op_i == 2'h1 |=> halt_o && indicator_o && key_ready_o; endproperty
    a_type_halt: assert property (p_type_halt) else $error("no halt on type-in");
    property p_key_write; key_valid_i && key_ready_o |=> mem_we_o && !key_ready_o
        && mem_wdata_o == $past(key_word_i); endproperty
    a_key_write: assert property (p_key_write) else $error("key word not written");
    property p_we_addr; mem_we_o |-> mem_addr_o == addr_r; endproperty
    a_we_addr: assert property (p_we_addr) else $error("write address wrong");
    property p_print_read; take && instr_op_i == 2'h2 |=> mem_re_o && mem_addr_o == addr_r; endproperty
    a_print_read: assert property (p_print_read) else $error("print read wrong");
    property p_print_done; take && instr_op_i == 2'h2 && !prn_valid_o
        |=> !done_o [*2] ##1 done_o && prn_valid_o; endproperty
    a_print_done: assert property (p_print_done) else $error("print done late");
    property p_prn_word; mem_re_o && !prn_valid_o |-> ##2 prn_word_o == $past(mem_rdata_i); endproperty
    a_prn_word: assert property (p_prn_word) else $error("held word wrong");
    property p_halt_hold; halt_o && !release_i |=> halt_o; endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt dropped");
    property p_resume; done_o && $past(halt_o) |-> !halt_o && !indicator_o && $past(release_i);
    endproperty
    a_resume: assert property (p_resume) else $error("resume wrong");
    c_type: cover property (take && instr_op_i == 2'h1);
    c_print: cover property (take && instr_op_i == 2'h2);
    c_full: cover property (take && prn_valid_o);
endmodule : cwio_console_props
bind cwio_console_unit cwio_console_props i_props (.*);

// ### verification/cwio_console_model.sv
/* Console keyboard and printer model.
 Assumes the bench sets the word and the operator delay. */
`timescale 1ns/1ps
module cwio_console_model
(
    input wire logic clk_i,
    input wire logic key_ready_i,
    input wire logic prn_valid_i,
    input wire logic [47:0] prn_word_i,
    input wire logic [47:0] word_i,
    input wire logic [3:0] dly_i,
    output logic key_valid_o,
    output logic [47:0] key_word_o,
    output logic release_o,
    output logic prn_ready_o,
    output logic [47:0] printed_o
);
    logic [3:0] cnt_r = 4'h0; // Operator or printer wait
    logic [4:0] rel_r = 5'h0; // Release countdown
    initial {key_valid_o, key_word_o, release_o, prn_ready_o, printed_o} = '0;
    always @(posedge clk_i)
    begin
        cnt_r <= (key_ready_i || prn_valid_i) ? cnt_r + 4'(cnt_r != dly_i) : 4'h0;
        // One word per open keyboard; idle data inverted
        key_valid_o <= key_ready_i && cnt_r == dly_i && !key_valid_o;
        key_word_o <= (key_ready_i && cnt_r == dly_i && !key_valid_o) ? word_i : ~word_i;
        // Release comes a while after the word
        rel_r <= (key_valid_o && key_ready_i) ? 5'(dly_i) + 5'h2 : rel_r - 5'(rel_r != 0);
        release_o <= rel_r == 5'h1;
        // Printer stalls, then takes the held word
        prn_ready_o <= prn_valid_i && cnt_r == dly_i && !prn_ready_o;
        if (prn_valid_i && prn_ready_o)
            printed_o <= prn_word_i;
    end
endmodule : cwio_console_model

// ### verification/tb_top.sv
/* Bench for the console unit.
 Assumes the console model and a one-cycle memory here. */
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0, reset_i = 1, iv = 0, rel, kv, re, we, done, halt, ind, kr, pv, pr;
    logic [1:0] op = 0;
    logic [9:0] addr = 0, ma;
    logic [47:0] kw, wd, pw, printed, word = 0, rd = 0, mem [1024];
    logic [3:0] dly = 0;
    int num_errors = 0, samples_checked = 0;
    cwio_console_unit i_dut (.clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(iv), .instr_op_i(op),
        .instr_addr_i(addr), .key_valid_i(kv), .key_word_i(kw), .release_i(rel),
        .mem_rdata_i(rd), .prn_ready_i(pr), .done_o(done), .halt_o(halt), .indicator_o(ind),
        .key_ready_o(kr), .mem_we_o(we), .mem_re_o(re), .mem_addr_o(ma), .mem_wdata_o(wd),
        .prn_valid_o(pv), .prn_word_o(pw));
    cwio_console_model i_con (.clk_i(clk_i), .key_ready_i(kr), .prn_valid_i(pv), .prn_word_i(pw),
        .word_i(word), .dly_i(dly), .key_valid_o(kv), .key_word_o(kw), .release_o(rel),
        .prn_ready_o(pr), .printed_o(printed));
    initial forever #5 clk_i = ~clk_i;
    // Memory with one-cycle read
    always @(posedge clk_i)
    begin
        if (we === 1'b1) mem[ma] <= wd;
        rd <= (re === 1'b1) ? mem[ma] : ~rd;
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic issue(input logic [1:0] o, input logic [9:0] a);
        @(posedge clk_i);
        iv <= 1'b1; op <= o; addr <= a;
        @(posedge clk_i);
        iv <= 1'b0;
    endtask : issue
    task automatic wait_done(output int n);
        n = 0;
        do begin @(posedge clk_i); #1; n++; end while (done !== 1'b1 && n < 200);
        check(done, 1'b1);
    endtask : wait_done
    task automatic t_type(input logic [9:0] a, input logic [47:0] w, input logic [3:0] d);
        int n;
        word <= w; dly <= d;
        issue(2'h1, a);
        @(posedge clk_i); #1;
        check({halt, ind, kr}, 3'h7);
        wait_done(n);
        check({halt, ind}, 2'h0);
        check(mem[a], w);
        $display("type-in test end");
    endtask : t_type
    task automatic t_print(input logic [9:0] a, input logic [47:0] w);
        int n;
        dly <= 4'h9;
        issue(2'h2, a);
        wait_done(n);
        check(n, 2);
        check(pv, 1'b1);
        check(pw, w);
        $display("print test end");
    endtask : t_print
    task automatic t_backlog(input logic [9:0] a, input logic [47:0] w, input logic [47:0] p);
        int n;
        issue(2'h2, a);
        wait_done(n);
        check(n > 2, 1'b1);
        check(printed, p);
        check(pw, w);
        for (int i = 0; i < 20 && printed !== w; i++) begin @(posedge clk_i); #1; end
        check(printed, w);
        $display("backlog test end");
    endtask : t_backlog
    task automatic test_done;
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        t_type(10'h000, 48'hA5A5_0F0F_C3C3, 4'h0);
        t_type(10'h3FF, 48'h1234_5678_9ABC, 4'h5);
        t_print(10'h000, 48'hA5A5_0F0F_C3C3);
        t_backlog(10'h3FF, 48'h1234_5678_9ABC, 48'hA5A5_0F0F_C3C3);
        test_done;
    end
    initial
    begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        test_done;
    end
endmodule : tb_top
